// ===== logic/isu_pkg.sv
// package for the upper interrupt status block
package isu_pkg;

  localparam logic [7:0] ISU_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] ISU_MASK_OFFSET = 8'h14;
  localparam logic [7:0] ISU_LOW_OFFSET = 8'h18;
  localparam logic [31:0] ISU_STATUS_RESET = 32'h0300_8000;
  localparam logic [31:0] ISU_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] ISU_STATUS_VALID = 32'h03F1_FF00;
  localparam logic [31:0] ISU_LOW_VALID = 32'h0000_00FF;
  localparam int ISU_BIT_SUMMARY = 15;
  localparam int ISU_HI_LSB = 16;
  localparam int ISU_HI_MSB = 25;
  localparam int ISU_EV_LSB = 8;
  localparam logic [31:0] ISU_MASK_VALID = 32'h03F1_FFFF;

  // status bit positions
  localparam int ISU_BIT_TX_RESET = 25;
  localparam int ISU_BIT_RX_RESET = 24;
  localparam int ISU_BIT_PARITY = 23;
  localparam int ISU_BIT_SYS_FAULT = 22;
  localparam int ISU_BIT_MASTER_ABORT = 21;
  localparam int ISU_BIT_TARGET_ABORT = 20;
  localparam int ISU_BIT_RS_OVERFLOW = 16;
  localparam int ISU_BIT_PHY = 14;
  localparam int ISU_BIT_WAKE = 13;
  localparam int ISU_BIT_SW_REQUEST = 12;
  localparam int ISU_BIT_STATS = 11;
  localparam int ISU_BIT_UNDERFLOW = 10;
  localparam int ISU_BIT_QUIET = 9;
  localparam int ISU_BIT_TX_FAIL = 8;

  // one request per source, bit i of src drives status bit i+8 except the summary and unused slots
  typedef struct packed {
    logic transmit_reset_done;
    logic receive_reset_done;
    logic parity_fault_seen;
    logic system_fault_signalled;
    logic master_abort_seen;
    logic target_abort_seen;
    logic [2:0] unused;
    logic receive_status_fifo_overflow;
    logic summary_slot;
    logic phy_event;
    logic wake_event;
    logic software_request;
    logic statistics_threshold_event;
    logic transmit_fifo_underflow;
    logic transmit_went_quiet;
    logic transmit_failure;
  } isu_events_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } isu_bus_t;

endpackage

// ===== logic/isu_status.sv
// upper-half interrupt status register with mask and interrupt output
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
// What this block does
// - interrupt only when set bit also enabled
// - status records events regardless of mask
// - read returns pending bits, then clears all but events arriving in the read cycle
// - writes to status change nothing
// - 32-bit status, resets to 03008000h
// - bit 25 transmit reset finished
// - bit 24 receive reset finished
// - bit 23 follows parity fault flag set
// - bit 22 device signalled system error
// - bit 21 master abort received
// - bit 20 target abort received
// - bit 16 receive status fifo overflow
// - bit 15 is OR of 25..16
// - bit 14 transceiver interrupt
// - bit 13 wake condition detected
// - bit 12 software request bit set
// - bit 11 statistics threshold reached
// - bit 10 transmit fifo underrun
// - bit 9 transmit machine went idle
// - bit 8 failed transmit written back
// - mask cleared by reset
module isu_status
  import isu_pkg::*;
(
  input wire logic clk, // 40 MHz clock
  input wire logic srst, // sync reset, hard or soft
  input wire logic ce, // clock enable
  input wire isu_bus_t bus, // register port request
  input wire isu_events_t events, // event pulses or levels
  input wire logic [7:0] low_events, // lower status events from neighbours
  output logic [31:0] rdata, // read data, cycle after read
  output logic irq // interrupt request, active high
);

  // ==========================================
  // status and mask next state
  logic [31:0] status_q, status_d;
  logic [31:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [31:0] set_vec;
  logic rd_status;
  logic rd_mask;
  logic wr_mask;

  // one compare shared by every decode branch
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ==========================================
  // address decode
  // the status offset decodes no write strobe at all
  always_comb begin
    rd_status = 1'b0;
    rd_mask = 1'b0;
    wr_mask = 1'b0;
    if (hit(bus.addr, ISU_STATUS_OFFSET)) begin
      rd_status = bus.rd;
    end else if (hit(bus.addr, ISU_MASK_OFFSET)) begin
      rd_mask = bus.rd;
      wr_mask = bus.wr;
    end
  end

  // ==========================================
  // per-bit event steering
  // summary and unused slots of the event word never reach the status
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_ev
      if (gi < ISU_EV_LSB) begin : g_low
        assign set_vec[gi] = low_events[gi] & ISU_LOW_VALID[gi];
      end else if (gi == ISU_BIT_SUMMARY) begin : g_sum
        assign set_vec[gi] = 1'b0;
      end else if (gi <= ISU_HI_MSB) begin : g_hi
        assign set_vec[gi] = events[gi - ISU_EV_LSB] & ISU_STATUS_VALID[gi];
      end else begin : g_rsvd
        assign set_vec[gi] = 1'b0;
      end
    end
  endgenerate

  // ==========================================
  // status group
  // the set is applied after the clear so an event in the read cycle survives
  always_comb begin
    status_d = status_q;
    if (rd_status) begin
      status_d = 32'h0000_0000;
    end
    status_d = status_d | set_vec;
    status_d[ISU_BIT_SUMMARY] = |status_d[ISU_HI_MSB:ISU_HI_LSB];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status_q <= ISU_STATUS_RESET;
    end else if (ce) begin
      status_q <= status_d;
    end
  end

  // ==========================================
  // mask group
  always_comb begin
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = bus.wdata & ISU_MASK_VALID;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q <= ISU_MASK_RESET;
    end else if (ce) begin
      mask_q <= mask_d;
    end
  end

  // ==========================================
  // read data group
  // zero outside the cycle after a read, so a stale word never lingers
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_status) begin
      rdata_d = status_q;
    end else if (rd_mask) begin
      rdata_d = mask_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // interrupt group
  // built from next values so irq lines up with the stored status
  always_comb begin
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= irq_d;
    end
  end

  assign rdata = rdata_q;
  assign irq = irq_q;

  // ==========================================
  // checks
  a_summary_or: assert property (@(posedge clk) disable iff (srst)
    status_q[ISU_BIT_SUMMARY] == |status_q[ISU_HI_MSB:ISU_HI_LSB])
    else $error("summary bit not OR of high bits");
  a_reserved_zero: assert property (@(posedge clk) disable iff (srst)
    (status_q & ~(ISU_STATUS_VALID | ISU_LOW_VALID)) == 32'h0000_0000)
    else $error("reserved status bit set");
  a_read_returns: assert property (@(posedge clk) disable iff (srst)
    ce && bus.rd && bus.addr == ISU_STATUS_OFFSET |=> rdata == $past(status_q))
    else $error("status read returned wrong data");
  a_read_clears: assert property (@(posedge clk) disable iff (srst)
    ce && bus.rd && bus.addr == ISU_STATUS_OFFSET && events == '0 && low_events == 8'h00
    |=> status_q == 32'h0000_0000)
    else $error("status not cleared by read");
  a_event_kept: assert property (@(posedge clk) disable iff (srst)
    ce && bus.rd && bus.addr == ISU_STATUS_OFFSET && events.wake_event
    |=> status_q[ISU_BIT_WAKE])
    else $error("event lost");
  a_write_ignored: assert property (@(posedge clk) disable iff (srst)
    ce && bus.wr && !bus.rd && bus.addr == ISU_STATUS_OFFSET && events == '0
    && low_events == 8'h00 |=> status_q == $past(status_q))
    else $error("status write changed bits");
  a_irq_gated: assert property (@(posedge clk) disable iff (srst)
    ce |=> irq == |(status_q & mask_q))
    else $error("interrupt not status and mask");
  a_mask_reset: assert property (@(posedge clk)
    srst |=> mask_q == 32'h0000_0000 && status_q == 32'h0300_8000 && !irq)
    else $error("reset values wrong");
  a_parity_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.parity_fault_seen |=> status_q[23] && status_q[ISU_BIT_SUMMARY])
    else $error("parity flag not recorded");

  // ==========================================
  // checks: one event per status bit
  a_txrst_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.transmit_reset_done
    |=> status_q[ISU_BIT_TX_RESET] && status_q[ISU_BIT_SUMMARY])
    else $error("transmit reset done not recorded");

  a_rxrst_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.receive_reset_done
    |=> status_q[ISU_BIT_RX_RESET] && status_q[ISU_BIT_SUMMARY])
    else $error("receive reset done not recorded");

  a_sysfault_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.system_fault_signalled
    |=> status_q[ISU_BIT_SYS_FAULT] && status_q[ISU_BIT_SUMMARY])
    else $error("system fault not recorded");

  a_mabort_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.master_abort_seen
    |=> status_q[ISU_BIT_MASTER_ABORT] && status_q[ISU_BIT_SUMMARY])
    else $error("master abort not recorded");

  a_tabort_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.target_abort_seen
    |=> status_q[ISU_BIT_TARGET_ABORT] && status_q[ISU_BIT_SUMMARY])
    else $error("target abort not recorded");

  a_rsfifo_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.receive_status_fifo_overflow
    |=> status_q[ISU_BIT_RS_OVERFLOW] && status_q[ISU_BIT_SUMMARY])
    else $error("status fifo overflow not recorded");

  a_phy_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.phy_event
    |=> status_q[ISU_BIT_PHY])
    else $error("transceiver event not recorded");

  a_wake_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.wake_event
    |=> status_q[ISU_BIT_WAKE])
    else $error("wake event not recorded");

  a_swreq_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.software_request
    |=> status_q[ISU_BIT_SW_REQUEST])
    else $error("software request not recorded");

  a_stats_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.statistics_threshold_event
    |=> status_q[ISU_BIT_STATS])
    else $error("statistics event not recorded");

  a_underflow_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.transmit_fifo_underflow
    |=> status_q[ISU_BIT_UNDERFLOW])
    else $error("transmit underflow not recorded");

  a_quiet_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.transmit_went_quiet
    |=> status_q[ISU_BIT_QUIET])
    else $error("transmit idle not recorded");

  a_txfail_sets: assert property (@(posedge clk) disable iff (srst)
    ce && events.transmit_failure
    |=> status_q[ISU_BIT_TX_FAIL])
    else $error("transmit failure not recorded");

  // ==========================================
  // checks: bus, freeze and interrupt
  a_ce_freeze: assert property (@(posedge clk) disable iff (srst)
    !ce && !srst
    |=> status_q == $past(status_q) && mask_q == $past(mask_q)
    && rdata == $past(rdata) && irq == $past(irq))
    else $error("state moved while clock enable low");

  a_bits_sticky: assert property (@(posedge clk) disable iff (srst)
    ce && !(bus.rd && bus.addr == ISU_STATUS_OFFSET)
    |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("status bit lost without a read");

  a_no_spurious: assert property (@(posedge clk) disable iff (srst)
    ce
    |=> (status_q & ~$past(status_q) & ~$past(set_vec) & ~32'h0000_8000) == 32'h0000_0000)
    else $error("status bit set without an event");

  a_mask_write: assert property (@(posedge clk) disable iff (srst)
    ce && bus.wr && bus.addr == ISU_MASK_OFFSET
    |=> mask_q == ($past(bus.wdata) & 32'h03F1_FFFF))
    else $error("mask write did not land");

  a_mask_read: assert property (@(posedge clk) disable iff (srst)
    ce && bus.rd && bus.addr == ISU_MASK_OFFSET
    |=> rdata == $past(mask_q))
    else $error("mask read returned wrong data");

  a_rdata_idle: assert property (@(posedge clk) disable iff (srst)
    ce && !bus.rd |=> rdata == 32'h0000_0000)
    else $error("read data stood without a read");

  a_irq_needs_set: assert property (@(posedge clk) disable iff (srst)
    irq |-> |(status_q & mask_q))
    else $error("interrupt without an enabled status bit");

  a_irq_low_mask: assert property (@(posedge clk) disable iff (srst)
    ce && mask_d == 32'h0000_0000 |=> !irq)
    else $error("interrupt with every enable clear");

  a_rsvd_dropped: assert property (@(posedge clk) disable iff (srst)
    ce && events.unused != 3'b000
    |=> status_q[19:17] == 3'b000)
    else $error("unused event slot reached status");

  a_reset_rdata: assert property (@(posedge clk)
    srst |=> rdata == 32'h0000_0000)
    else $error("read data not cleared by reset");

  // ==========================================
  // checks: every enabled bit raises the interrupt
  genvar gk;
  generate
    for (gk = 0; gk < 32; gk = gk + 1) begin : g_irq_chk
      a_bit_raises: assert property (@(posedge clk) disable iff (srst)
        ce && status_d[gk] && mask_d[gk]
        |=> irq)
        else $error("enabled status bit did not raise interrupt");
    end
  endgenerate

  // ==========================================
  // checks: reset value stands until the first clearing read
  logic seen_read_q, seen_read_d;
  always_comb begin
    seen_read_d = seen_read_q;
    if (ce && rd_status) begin
      seen_read_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seen_read_q <= 1'b0;
    end else begin
      seen_read_q <= seen_read_d;
    end
  end

  a_reset_holds: assert property (@(posedge clk) disable iff (srst)
    !seen_read_q |-> status_q[ISU_BIT_TX_RESET] && status_q[ISU_BIT_RX_RESET]
    && status_q[ISU_BIT_SUMMARY])
    else $error("reset status bits lost before first read");

endmodule // isu_status

// ===== verification/isu_host.sv
// host model issuing register accesses
`timescale 1ns/10ps
module isu_host
  import isu_pkg::*;
(
  input wire logic clk, // bench clock
  input wire logic [31:0] rdata, // read data from the device
  output isu_bus_t bus // register requests
);
  initial bus = '0;
  // q takes read data mid-cycle, in the one cycle where it stands
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask
endmodule // isu_host

// ===== verification/test_interrupt_status_upper_events.sv
// self-checking bench for the upper interrupt status block
`timescale 1ns/10ps
module test_interrupt_status_upper_events;
  import isu_pkg::*;
  logic clk = 0;
  logic srst = 1;
  logic ce = 1;
  isu_bus_t bus;
  isu_events_t events = '0;
  logic [7:0] low_events = '0;
  logic [31:0] rdata, q, m, e;
  logic [17:0] ev;
  logic [7:0] lo;
  logic irq;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  isu_status i_dut (.clk(clk), .srst(srst), .ce(ce), .bus(bus), .events(events),
    .low_events(low_events), .rdata(rdata), .irq(irq));
  isu_host i_host (.clk(clk), .rdata(rdata), .bus(bus));
  function automatic logic [31:0] expect_of(logic [17:0] v, logic [7:0] l);
    logic [31:0] s;
    s = {6'h00, v, l} & 32'h03F1_7FFF;
    s[15] = |s[25:16];
    return s;
  endfunction
  task automatic chk_word(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(logic got, logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t irq got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    void'($urandom(32'ha736));
    repeat (5) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    i_host.access(1'b0, 8'h10, 32'h0, q);
    chk_word(q, ISU_STATUS_RESET);
    chk_irq(irq, 1'b0);
    for (int i = 0; i < 8; i++) begin
      ev = (i == 0) ? '1 : 18'($urandom);
      lo = 8'($urandom);
      m = (i == 1) ? 32'h0 : $urandom;
      i_host.access(1'b1, 8'h14, m, q);
      i_host.access(1'b0, 8'h14, 32'h0, q);
      chk_word(q, m & 32'h03F1_FFFF);
      i_host.access(1'b1, 8'h10, $urandom, q);
      events <= ev;
      low_events <= lo;
      e = expect_of(ev, lo);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk_irq(irq, |(e & m));
      @(posedge clk);
      i_host.access(1'b0, 8'h10, 32'h0, q);
      chk_word(q, e);
      events <= '0;
      low_events <= '0;
      i_host.access(1'b0, 8'h10, 32'h0, q);
      chk_word(q, e);
      i_host.access(1'b0, 8'h1C, 32'h0, q);
      chk_word(q, 32'h0);
      i_host.access(1'b0, 8'h10, 32'h0, q);
      chk_word(q, 32'h0);
    end
    // clock enable low: neither events nor a read may touch state
    ce <= 1'b0;
    events <= '1;
    i_host.access(1'b0, 8'h10, 32'h0, q);
    events <= '0;
    ce <= 1'b1;
    i_host.access(1'b0, 8'h10, 32'h0, q);
    chk_word(q, 32'h0000_0000);
    // soft reset in mid-run, mask still holds the last random value
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk_irq(irq, 1'b0);
    @(posedge clk);
    i_host.access(1'b0, 8'h10, 32'h0, q);
    chk_word(q, ISU_STATUS_RESET);
    i_host.access(1'b0, 8'h14, 32'h0, q);
    chk_word(q, 32'h0000_0000);
    finish_test;
  end
endmodule // test_interrupt_status_upper_events
